// *** hdl/feu_map.vh ***
// Register map constants for the fault-enable upper byte block.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef FEU_MAP_VH
`define FEU_MAP_VH

////////////////////////////////////////////////////////////////////////////////
// Addresses on the internal register port
`define FEU_ADDR_W            8
`define FEU_ADDR_FAULT_ENABLE 8'h07
`define FEU_ADDR_FAULT_STATUS 8'h06
`define FEU_ADDR_CLOCK_COUNT  8'h30

////////////////////////////////////////////////////////////////////////////////
// Fault-enable register layout and reset
`define FEU_DATA_W            16
`define FEU_FAULT_ENABLE_RST  16'h0040
`define FEU_FAULT_ENABLE_WMSK 16'h1FFF
`define FEU_BIT_CLK_CNT_EN    12
`define FEU_BIT_POS_IN_EN     11
`define FEU_BIT_NEG_IN_EN     10
`define FEU_BIT_REF_RANGE_EN  9
`define FEU_BIT_REF_MISS_EN   8

////////////////////////////////////////////////////////////////////////////////
// Fault status register layout (write one to clear) and reset
`define FEU_FAULT_STATUS_RST  4'h0
`define FEU_FLAG_POS_IN       3
`define FEU_FLAG_NEG_IN       2
`define FEU_FLAG_REF_RANGE    1
`define FEU_FLAG_REF_MISS     0

////////////////////////////////////////////////////////////////////////////////
// Clock cycle counter
`define FEU_COUNT_W           16
`define FEU_COUNT_RST         16'h0000

////////////////////////////////////////////////////////////////////////////////
// Read answer
`define FEU_RDATA_RST         16'h0000
`define FEU_RVALID_RST        1'h0

`endif

// *** hdl/feu_fault_enable.v ***
// Fault-enable upper bits: enable register, gated sticky fault flags and
// the modulator clock cycle counter, behind the internal register port.
// Assumes the serial interface decodes frames into single-cycle read and
// write strobes on sys_clk, and detector levels are synchronous to sys_clk.
// Reserved bits and unmapped addresses read back as zero.
//
// Contract
// R1: bit 12 enables the modulator clock cycle counter; reset clear.
// R2: bit 11 gates positive input range fault into its status flag; reset clear.
// R3: bit 10 gates negative input range fault into its status flag; reset clear.
// R4: bit 9 gates external reference range fault into its flag; reset clear.
// R5: bit 8 gates external reference missing fault into its flag; reset clear.
// R6: bits 15 to 13 read zero and ignore writes.
// R7: register sits at address 0x07, whole-register reset value 0x0040.
// R8: gated flags stay set until host writes one to their bit.
`include "feu_map.vh"
`default_nettype none

module feu_fault_enable (
   input  wire                       sys_clk,
   input  wire                       sys_rst,
   // Register port, strobes last one cycle
   input  wire                       reg_wr,
   input  wire                       reg_rd,
   input  wire [`FEU_ADDR_W-1:0]     reg_addr,
   input  wire [`FEU_DATA_W-1:0]     reg_wdata,
   output reg  [`FEU_DATA_W-1:0]     reg_rdata_q,
   output reg                        reg_rvalid_q,
   // Modulator clock tick and detector levels
   input  wire                       mod_clk_tick,
   input  wire                       pos_input_range_det,
   input  wire                       neg_input_range_det,
   input  wire                       ext_ref_range_det,
   input  wire                       ext_ref_missing_det,
   // Register contents for the rest of the converter
   output reg  [`FEU_DATA_W-1:0]     fault_enable_q,
   output reg  [3:0]                 fault_status_q,
   output reg  [`FEU_COUNT_W-1:0]    clock_count_q
);

   ////////////////////////////////////////////////////////////////////////////
   // Helper functions

   // Full compare; the port carries no partial decode
   function hit;
      input [`FEU_ADDR_W-1:0] addr;
      input [`FEU_ADDR_W-1:0] target;
      begin
         hit = (addr == target);
      end
   endfunction

   // Drops the reserved top bits, on the way in and on the way out
   function [`FEU_DATA_W-1:0] writable;
      input [`FEU_DATA_W-1:0] value;
      begin
         writable = value & `FEU_FAULT_ENABLE_WMSK;
      end
   endfunction

   // A detector level only counts while its enable bit is set
   function gate;
      input level;
      input enable;
      begin
         gate = level & enable;
      end
   endfunction

   // Sticky flag: a set beats a same-cycle clear, so no fault is lost
   function sticky;
      input flag_in;
      input clr_in;
      input set_in;
      begin
         sticky = (flag_in & ~clr_in) | set_in;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Decode

   // Writes to the count register or to unmapped addresses fall through
   wire wr_enable = reg_wr & hit(reg_addr, `FEU_ADDR_FAULT_ENABLE);  // see R7
   wire wr_status = reg_wr & hit(reg_addr, `FEU_ADDR_FAULT_STATUS);  // see R8

   ////////////////////////////////////////////////////////////////////////////
   // Fault-enable register

   reg [`FEU_DATA_W-1:0] fault_enable_d;

   always @* begin
      fault_enable_d = fault_enable_q;
      if (wr_enable) begin
         // Reserved top bits are masked off so they always read zero
         fault_enable_d = writable(reg_wdata);  // see R6
      end
   end

   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fault_enable_q <= `FEU_FAULT_ENABLE_RST;  // see R7
      end else begin
         fault_enable_q <= fault_enable_d;  // see R1
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Gated sticky fault flags

   reg [3:0] fault_set;
   reg [3:0] fault_clr;
   reg [3:0] fault_status_d;

   always @* begin
      fault_set = 4'h0;
      fault_set[`FEU_FLAG_POS_IN] = gate(pos_input_range_det,
                                         fault_enable_q[`FEU_BIT_POS_IN_EN]);  // see R2
      fault_set[`FEU_FLAG_NEG_IN] = gate(neg_input_range_det,
                                         fault_enable_q[`FEU_BIT_NEG_IN_EN]);  // see R3
      fault_set[`FEU_FLAG_REF_RANGE] = gate(ext_ref_range_det,
                                            fault_enable_q[`FEU_BIT_REF_RANGE_EN]);  // see R4
      fault_set[`FEU_FLAG_REF_MISS] = gate(ext_ref_missing_det,
                                           fault_enable_q[`FEU_BIT_REF_MISS_EN]);  // see R5
   end

   always @* begin
      fault_clr = 4'h0;
      if (wr_status) begin
         // Only the four flag bits of the written word take part
         fault_clr = reg_wdata[3:0];  // see R8
      end
   end

   always @* begin
      fault_status_d = fault_status_q;
      fault_status_d[`FEU_FLAG_POS_IN] =
         sticky(fault_status_q[`FEU_FLAG_POS_IN], fault_clr[`FEU_FLAG_POS_IN],
                fault_set[`FEU_FLAG_POS_IN]);  // see R8
      fault_status_d[`FEU_FLAG_NEG_IN] =
         sticky(fault_status_q[`FEU_FLAG_NEG_IN], fault_clr[`FEU_FLAG_NEG_IN],
                fault_set[`FEU_FLAG_NEG_IN]);  // see R8
      fault_status_d[`FEU_FLAG_REF_RANGE] =
         sticky(fault_status_q[`FEU_FLAG_REF_RANGE], fault_clr[`FEU_FLAG_REF_RANGE],
                fault_set[`FEU_FLAG_REF_RANGE]);  // see R8
      fault_status_d[`FEU_FLAG_REF_MISS] =
         sticky(fault_status_q[`FEU_FLAG_REF_MISS], fault_clr[`FEU_FLAG_REF_MISS],
                fault_set[`FEU_FLAG_REF_MISS]);  // see R8
   end

   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         fault_status_q <= `FEU_FAULT_STATUS_RST;
      end else begin
         fault_status_q <= fault_status_d;  // see R8
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Modulator clock cycle counter

   reg [`FEU_COUNT_W-1:0] clock_count_d;

   always @* begin
      clock_count_d = clock_count_q;
      // Holds its value while disabled so software can still read the total
      // Wraps silently; software works with differences between two reads
      if (fault_enable_q[`FEU_BIT_CLK_CNT_EN] && mod_clk_tick) begin  // see R1
         clock_count_d = clock_count_q + 16'h0001;
      end
   end

   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         clock_count_q <= `FEU_COUNT_RST;
      end else begin
         clock_count_q <= clock_count_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read path, one cycle of latency; unmapped addresses read zero

   reg [`FEU_DATA_W-1:0] reg_rdata_d;

   always @* begin
      reg_rdata_d = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            `FEU_ADDR_FAULT_ENABLE: begin
               reg_rdata_d = writable(fault_enable_q);  // see R6
            end
            `FEU_ADDR_FAULT_STATUS: begin
               reg_rdata_d = {12'h000, fault_status_q};
            end
            `FEU_ADDR_CLOCK_COUNT: begin
               reg_rdata_d = clock_count_q;  // see R1
            end
            default: begin
               reg_rdata_d = 16'h0000;
            end
         endcase
      end
   end

   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rdata_q <= `FEU_RDATA_RST;
      end else begin
         reg_rdata_q <= reg_rdata_d;
      end
   end

   // Every read, mapped or not, is answered exactly one cycle after its strobe
   always @(posedge sys_clk or posedge sys_rst) begin
      if (sys_rst) begin
         reg_rvalid_q <= `FEU_RVALID_RST;
      end else begin
         reg_rvalid_q <= reg_rd;
      end
   end

endmodule // feu_fault_enable

`default_nettype wire

// *** test/feu_host.sv ***
// Host model: issues single register accesses on the block's register port.
// Assumes the bench clock; signals move only on falling edges.
`default_nettype none
module feu_host (
   input  wire logic        clk,
   output var  logic        wr,
   output var  logic        rd,
   output var  logic [7:0]  addr,
   output var  logic [15:0] wdata
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      {wr, rd, addr, wdata} = 26'h0;
   end
   task automatic acc(input bit w, input logic [7:0] a, input logic [15:0] d);
      @(negedge clk);
      {wr, rd, addr, wdata} = {w, !w, a, d};
      @(negedge clk);
      // Released lines show no stale value
      {wr, rd, addr, wdata} = {2'b00, ~a, ~d};
   endtask
endmodule // feu_host
`default_nettype wire

// *** test/feu_chk_assertions.sv ***
// Checker for the fault-enable block; sees only its ports.
// Assumes the bind at the foot of this file.
`default_nettype none
module feu_chk (
   input wire logic sys_clk, sys_rst, reg_wr, reg_rd, reg_rvalid_q, mod_clk_tick,
   input wire logic pos_input_range_det, neg_input_range_det, ext_ref_range_det,
   input wire logic ext_ref_missing_det,
   input wire logic [7:0] reg_addr,
   input wire logic [15:0] reg_wdata, reg_rdata_q, fault_enable_q, clock_count_q,
   input wire logic [3:0] fault_status_q
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (sys_rst);
   a_read_answer: assert property (reg_rd |=> reg_rvalid_q) else $error("no read answer");
   a_read_only: assert property (!reg_rd |=> !reg_rvalid_q) else $error("stray read answer");
   a_rsvd_zero: assert property (fault_enable_q[15:13] == 3'h0)
      else $error("reserved set");
   a_enable_write: assert property (
      reg_wr && reg_addr == 8'h07 |=> fault_enable_q == ($past(reg_wdata) & 16'h1FFF))
      else $error("enable write");
   a_pos_gate: assert property (
      !fault_status_q[3] && !(pos_input_range_det && fault_enable_q[11]) |=> !fault_status_q[3])
      else $error("ungated flag");
   a_neg_gate: assert property (
      !fault_status_q[2] && !(neg_input_range_det && fault_enable_q[10]) |=> !fault_status_q[2])
      else $error("ungated flag");
   a_ref_gate: assert property (
      !fault_status_q[1] && !(ext_ref_range_det && fault_enable_q[9]) |=> !fault_status_q[1])
      else $error("ungated flag");
   a_miss_gate: assert property (
      !fault_status_q[0] && !(ext_ref_missing_det && fault_enable_q[8]) |=> !fault_status_q[0])
      else $error("ungated flag");
   a_flag_sticky: assert property (
      fault_status_q[0] && !(reg_wr && reg_addr == 8'h06 && reg_wdata[0]) |=> fault_status_q[0])
      else $error("flag lost");
   a_flag_clear: assert property (
      reg_wr && reg_addr == 8'h06 && reg_wdata[0] &&
      !(ext_ref_missing_det && fault_enable_q[8]) |=> !fault_status_q[0])
      else $error("flag not cleared");
   a_count_run: assert property (
      mod_clk_tick && fault_enable_q[12] |=> clock_count_q == $past(clock_count_q) + 16'h0001)
      else $error("count step");
   a_count_hold: assert property (
      !(mod_clk_tick && fault_enable_q[12]) |=> $stable(clock_count_q))
      else $error("count moved");
endmodule // feu_chk
bind feu_fault_enable feu_chk u_chk (.*);
`default_nettype wire

// *** test/feu_fault_enable_tb.sv ***
// Bench for the fault-enable block: host model, detectors, read scoreboard.
// Assumes the design, host model and checker are compiled before it.
`default_nettype none
`define CHK(g, x) begin total_checks++; if ((g) !== (x)) begin mismatches++; \
   $display("wrong value at %0t: got %h exp %h", $time, g, x); end end
module feu_fault_enable_tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 0, sys_rst = 1, tick = 0;
   logic [3:0] det = 4'h0;
   logic [15:0] s = 16'hB708, e, q[$];
   int mismatches = 0, total_checks = 0, cnt = 0, n;
   wire w, r, rv;
   wire [7:0] a;
   wire [15:0] wd, rdq, fe, cc;
   wire [3:0] fs;
   feu_host host (.clk(sys_clk), .wr(w), .rd(r), .addr(a), .wdata(wd));
   feu_fault_enable dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .reg_wr(w), .reg_rd(r),
      .reg_addr(a), .reg_wdata(wd), .reg_rdata_q(rdq), .reg_rvalid_q(rv),
      .mod_clk_tick(tick), .pos_input_range_det(det[3]), .neg_input_range_det(det[2]),
      .ext_ref_range_det(det[1]), .ext_ref_missing_det(det[0]), .fault_enable_q(fe),
      .fault_status_q(fs), .clock_count_q(cc));
   function automatic logic [15:0] lf(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   task automatic rd(input logic [7:0] ad, input logic [15:0] x);
      q.push_back(x);
      host.acc(0, ad, 16'h0000);
   endtask
   task automatic complete_run();
      if (mismatches == 0 && total_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   initial forever #10 sys_clk = ~sys_clk;
   // Oldest noted read result is paired with each answer, looked at mid-cycle
   // where it is settled; outside an answer the read data must stay zero
   always @(negedge sys_clk) if (!sys_rst) begin
      if (rv === 1'b1) begin
         e = (q.size() != 0) ? q.pop_front() : ~rdq;
         `CHK(rdq, e)
      end else begin
         `CHK(rdq, 16'h0000)
      end
   end
   initial begin
      repeat (2) @(posedge sys_clk);
      @(negedge sys_clk) sys_rst = 0;
      `CHK(fe, 16'h0040)
      `CHK(fs, 4'h0)
      `CHK(cc, 16'h0000)
      rd(8'h07, 16'h0040);
      rd(8'h55, 16'h0000);
      host.acc(1, 8'h30, 16'hFFFF);
      rd(8'h30, 16'h0000);
      host.acc(1, 8'h07, 16'hFFFF);
      `CHK(fe, 16'h1FFF)
      rd(8'h07, 16'h1FFF);
      for (int i = 0; i < 8; i++) begin
         s = lf(s);
         host.acc(1, 8'h07, s & 16'h0F00);
         `CHK(fe, s & 16'h0F00)
         det = 4'hF;
         @(negedge sys_clk) det = 4'h0;
         `CHK(fs, s[11:8])
         rd(8'h06, {12'h000, s[11:8]});
         host.acc(1, 8'h06, 16'h000F);
         rd(8'h06, 16'h0000);
         n = s[2:0];
         cnt += n;
         host.acc(1, 8'h07, 16'h1000);
         repeat (n) begin @(negedge sys_clk) tick = 1; @(negedge sys_clk) tick = 0; end
         host.acc(1, 8'h07, 16'h0000);
         @(negedge sys_clk) tick = 1;
         @(negedge sys_clk) tick = 0;
         `CHK(cc, cnt[15:0])
         rd(8'h30, cnt[15:0]);
      end
      // A reset in mid-run must bring back the power-on contents
      @(negedge sys_clk) sys_rst = 1;
      @(negedge sys_clk);
      `CHK(fe, 16'h0040)
      `CHK(cc, 16'h0000)
      sys_rst = 0;
      rd(8'h07, 16'h0040);
      for (int k = 0; k < 8 && q.size() != 0; k++) @(posedge sys_clk);
      if (q.size() != 0) mismatches++;
      complete_run();
   end
endmodule // feu_fault_enable_tb
`default_nettype wire
